//--- rtl/bpie_cpu.sv
// Purpose: processor end: bus grant, interrupt entry and return
// Assumes: peripherals hold requests until granted
// Notes: memory is a small word array for stack and vectors
// Function
// RULE1: nearest device on a line wins grant
// RULE2: no limit on devices per line; code has two slots on each level line and two on the direct line
// RULE3: direct grant at bus cycle end, not rmw
// RULE4: direct grant within 3.5 us
// RULE5: direct transfer leaves processor state unchanged
// RULE6: direct transfers need no processor involvement
// RULE7: master moves words at memory speed
// RULE8: winner sends command with vector address
// RULE9: push status word, then instruction pointer
// RULE10: load pointer from vector, status from next
// RULE11: first service fetch within 7.2 us
// RULE12: return pops pointer then status, 4.5 us
// RULE13: service interruptible after first instruction
// RULE14: nesting pushes context, depth memory bound
// RULE15: exactly four leveled request lines
// RULE16: stack top register addresses top word
// RULE17: priority in status bits seven to five
// RULE18: requests at or below priority ignored
// RULE19: levels between instructions, direct between cycles
// RULE20: higher request line gets bus first
// RULE21: device releases bus after command taken
// RULE22: highest numbered pending level granted first
`timescale 1ns/10ps
`default_nettype none
`include "bpie_defines.svh"
module bpie_cpu
	import bpie_pkg::*;
(
	// link
	bpie_if.cpu bus,
	// user side
	input wire logic mclk,
	input wire logic resetn,
	input wire logic rmw_active,
	input wire logic return_request,
	input wire logic [2:0] prio_write,
	input wire logic prio_write_en,
	output logic [15:0] instruction_pointer,
	output logic [15:0] processor_state_word,
	output logic [15:0] stack_top_register,
	output logic fetch_strobe,
	output logic in_service
);
	// ==========================================
	// word memory for stack and vectors
	logic [15:0] mem [0:1023];
	bpie_state_t state;
	logic [1:0] bus_cnt;
	logic [1:0] insn_cnt;
	logic [15:0] vec;
	logic [2:0] prio;
	logic [3:0] above;
	logic [3:0] pick;
	logic bus_end;
	logic insn_end;
	logic rti_pending;
	logic first_done;
	logic [15:0] sp_dec;
	logic [15:0] sp_inc;

	// ==========================================
	// priority and selection
	assign prio = processor_state_word[`BPIE_PRIO_MSB:`BPIE_PRIO_LSB]; // RULE17
	assign bus_end = (bus_cnt == 2'(`BPIE_BUS_CYCLE - 1));
	assign insn_end = bus_end && (insn_cnt == 2'(`BPIE_INSN_CYCLES - 1));
	assign sp_dec = stack_top_register - `BPIE_WORD_STEP;
	assign sp_inc = stack_top_register + `BPIE_WORD_STEP;
	// levels above priority, bit i is level i plus four
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			above[i] = bus.leveled_request_line[i] &&
				(3'(i + `BPIE_LEVEL_BASE) > prio); // RULE18 RULE15
		end
	end
	// one-hot of highest numbered pending level
	always_comb begin
		pick = 4'h0;
		if (above[3]) pick = 4'h8; // RULE22 RULE20
		else if (above[2]) pick = 4'h4;
		else if (above[1]) pick = 4'h2;
		else if (above[0]) pick = 4'h1;
	end

	// ==========================================
	// bus cycle and instruction counters
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bus_cnt <= 2'h0;
			insn_cnt <= 2'h0;
		end else if (state == BPIE_RUN && !bus.direct_transfer_grant) begin
			bus_cnt <= bus_cnt + 2'h1;
			if (insn_end) insn_cnt <= 2'h0;
			else if (bus_end) insn_cnt <= insn_cnt + 2'h1;
		end
	end

	// ==========================================
	// direct transfer grant, held while master busy
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bus.direct_transfer_grant <= 1'b0;
		end else if (bus.direct_transfer_grant) begin
			// processor idles, no state touched
			if (!bus.direct_transfer_request && !bus.master_busy)
				bus.direct_transfer_grant <= 1'b0; // RULE5 RULE6
		end else if (state == BPIE_RUN && bus.direct_transfer_request &&
			bus_end && !rmw_active) begin
			bus.direct_transfer_grant <= 1'b1; // RULE3 RULE4 RULE19
		end
	end

	// ==========================================
	// sequencer: grant level, entry, return
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= BPIE_RUN;
			bus.level_grant <= 4'h0;
			bus.intr_cmd_taken <= 1'b0;
			vec <= 16'h0000;
			instruction_pointer <= `BPIE_PC_RESET;
			processor_state_word <= `BPIE_PSW_RESET;
			stack_top_register <= `BPIE_STACK_RESET;
			fetch_strobe <= 1'b0;
			in_service <= 1'b0;
			rti_pending <= 1'b0;
			first_done <= 1'b1;
		end else begin
			fetch_strobe <= 1'b0;
			bus.intr_cmd_taken <= 1'b0;
			if (return_request) rti_pending <= 1'b1;
			if (prio_write_en && state == BPIE_RUN)
				processor_state_word[`BPIE_PRIO_MSB:`BPIE_PRIO_LSB] <=
					prio_write; // RULE17
			case (state)
			BPIE_RUN: begin
				if (insn_end && !bus.direct_transfer_grant &&
					!bus.direct_transfer_request) begin
					fetch_strobe <= 1'b1;
					instruction_pointer <= instruction_pointer + `BPIE_WORD_STEP;
					first_done <= 1'b1;
					if (rti_pending || return_request) begin
						rti_pending <= 1'b0;
						state <= BPIE_POPPC; // RULE12
					end else if (|pick && first_done) begin
						bus.level_grant <= pick; // RULE13 RULE19
						state <= BPIE_GRANT;
					end
				end
			end
			BPIE_GRANT: begin
				state <= BPIE_WAITCMD;
			end
			BPIE_WAITCMD: begin
				if (bus.intr_cmd_valid) begin
					vec <= bus.intr_vector; // RULE8
					bus.intr_cmd_taken <= 1'b1;
					bus.level_grant <= 4'h0;
					state <= BPIE_PUSHPS;
				end
			end
			BPIE_PUSHPS: begin
				if (!bus.master_busy) begin // RULE21
					mem[sp_dec[10:1]] <= processor_state_word; // RULE9 RULE14
					stack_top_register <= sp_dec; // RULE16
					state <= BPIE_PUSHPC;
				end
			end
			BPIE_PUSHPC: begin
				mem[sp_dec[10:1]] <= instruction_pointer; // RULE9 RULE14
				stack_top_register <= sp_dec; // RULE16
				state <= BPIE_LDPC;
			end
			BPIE_LDPC: begin
				instruction_pointer <= mem[vec[10:1]]; // RULE10
				state <= BPIE_LDPS;
			end
			BPIE_LDPS: begin
				processor_state_word <= mem[vec[10:1] + 10'h001]; // RULE10
				in_service <= 1'b1;
				first_done <= 1'b0;
				fetch_strobe <= 1'b1; // RULE11
				state <= BPIE_RUN;
			end
			BPIE_POPPC: begin
				instruction_pointer <= mem[stack_top_register[10:1]]; // RULE12
				stack_top_register <= sp_inc; // RULE16
				state <= BPIE_POPPS;
			end
			BPIE_POPPS: begin
				processor_state_word <= mem[stack_top_register[10:1]]; // RULE12
				stack_top_register <= sp_inc;
				in_service <= (sp_inc != `BPIE_STACK_RESET);
				state <= BPIE_RUN;
			end
			default: state <= BPIE_RUN;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- rtl/bpie_defines.svh
// Purpose: constants for the bus priority and interrupt entry block
// Assumes: 250 MHz mclk, 4 ns period
// Notes: times in ns, counts in cycles
`ifndef BPIE_DEFINES_SVH
`define BPIE_DEFINES_SVH
`define BPIE_CLK_PERIOD_NS 4
`define BPIE_GRANT_MAX_NS 3500
`define BPIE_GRANT_MAX_CYC (`BPIE_GRANT_MAX_NS / `BPIE_CLK_PERIOD_NS)
`define BPIE_ENTRY_MAX_NS 7200
`define BPIE_ENTRY_MAX_CYC (`BPIE_ENTRY_MAX_NS / `BPIE_CLK_PERIOD_NS)
`define BPIE_RETURN_NS 4500
`define BPIE_RETURN_CYC (`BPIE_RETURN_NS / `BPIE_CLK_PERIOD_NS)
`define BPIE_WORD_NS 1200
`define BPIE_WORD_CYC (`BPIE_WORD_NS / `BPIE_CLK_PERIOD_NS)
`define BPIE_PRIO_LSB 5
`define BPIE_PRIO_MSB 7
`define BPIE_WORD_STEP 16'h0002
`define BPIE_STACK_RESET 16'h0400
`define BPIE_PSW_RESET 16'h00E0
`define BPIE_PC_RESET 16'h0200
`define BPIE_BUS_CYCLE 4
`define BPIE_INSN_CYCLES 3
`define BPIE_LEVEL_BASE 4
`endif

//--- rtl/bpie_pkg.sv
// Purpose: types for the bus priority and interrupt entry block
// Assumes: nothing
// Notes: processor sequencer states
package bpie_pkg;
	typedef enum logic [3:0] {
		BPIE_RUN = 4'h0,
		BPIE_GRANT = 4'h1,
		BPIE_WAITCMD = 4'h3,
		BPIE_PUSHPS = 4'h2,
		BPIE_PUSHPC = 4'h6,
		BPIE_LDPC = 4'h7,
		BPIE_LDPS = 4'h5,
		BPIE_POPPC = 4'h4,
		BPIE_POPPS = 4'hC
	} bpie_state_t;
endpackage

//--- rtl/bpie_if.sv
// Purpose: request and grant link between processor and bus masters
// Assumes: single clock, one party per modport
// Notes: grant chains resolved by the device end
`timescale 1ns/10ps
`default_nettype none
interface bpie_if (input wire logic mclk, input wire logic resetn);
	logic direct_transfer_request;
	logic direct_transfer_grant;
	logic [3:0] leveled_request_line;
	logic [3:0] level_grant;
	logic master_busy;
	logic intr_cmd_valid;
	logic [15:0] intr_vector;
	logic intr_cmd_taken;
	modport cpu (
		input direct_transfer_request, leveled_request_line, master_busy,
		input intr_cmd_valid, intr_vector,
		output direct_transfer_grant, level_grant, intr_cmd_taken
	);
	modport periph (
		output direct_transfer_request, leveled_request_line, master_busy,
		output intr_cmd_valid, intr_vector,
		input direct_transfer_grant, level_grant, intr_cmd_taken
	);
endinterface
`default_nettype wire

//--- rtl/bpie_periph.sv
// Purpose: peripheral end: chained requesters on shared lines
// Assumes: user holds a request until done
// Notes: slot zero is nearest the processor on each chain
`timescale 1ns/10ps
`default_nettype none
`include "bpie_defines.svh"
module bpie_periph
	import bpie_pkg::*;
(
	// link
	bpie_if.periph bus,
	// user side
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [1:0] dma_want,
	input wire logic [3:0] [1:0] irq_want,
	input wire logic [3:0] [1:0] [15:0] irq_vector,
	output logic [1:0] dma_owner,
	output logic [3:0] [1:0] irq_served,
	output logic word_strobe
);
	// ==========================================
	// registered request lines; two slots on each line are ORed in
	logic [1:0] dma_win;
	logic [1:0] next_owner;
	logic [3:0] [1:0] irq_win;
	logic [15:0] word_cnt;
	logic cmd_pend;
	logic [15:0] cmd_vec;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bus.direct_transfer_request <= 1'b0;
			bus.leveled_request_line <= 4'h0;
		end else begin
			bus.direct_transfer_request <= |dma_want; // RULE2
			for (int l = 0; l < 4; l++)
				bus.leveled_request_line[l] <= |irq_want[l]; // RULE2
		end
	end
	// daisy chain: nearest slot takes the grant
	assign dma_win = dma_want[0] ? 2'h1 : {dma_want[1], 1'b0}; // RULE1
	always_comb begin
		for (int l = 0; l < 4; l++)
			irq_win[l] = irq_want[l][0] ? 2'h1 : {irq_want[l][1], 1'b0}; // RULE1
	end

	// ==========================================
	// direct transfer master, paced at memory speed
	// owner follows the grant, drops once its slot lets go
	always_comb begin
		next_owner = dma_owner;
		if (bus.direct_transfer_grant && dma_owner == 2'h0)
			next_owner = dma_win; // RULE6
		else if ((dma_owner & dma_want) == 2'h0)
			next_owner = 2'h0;
	end
	// owner, busy flag and word pacing
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dma_owner <= 2'h0;
			bus.master_busy <= 1'b0;
			word_cnt <= 16'h0000;
			word_strobe <= 1'b0;
		end else begin
			word_strobe <= 1'b0;
			dma_owner <= next_owner;
			bus.master_busy <= (next_owner != 2'h0); // RULE21
			if (dma_owner != 2'h0) begin
				if (word_cnt == 16'(`BPIE_WORD_CYC - 1)) begin
					word_cnt <= 16'h0000;
					word_strobe <= 1'b1; // RULE7
				end else begin
					word_cnt <= word_cnt + 16'h0001;
				end
			end else begin
				word_cnt <= 16'h0000;
			end
		end
	end

	// ==========================================
	// interrupt command after a level grant
	always_comb begin
		cmd_vec = 16'h0000;
		for (int l = 0; l < 4; l++)
			if (bus.level_grant[l])
				cmd_vec = irq_win[l][0] ? irq_vector[l][0] : irq_vector[l][1];
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cmd_pend <= 1'b0;
			bus.intr_vector <= 16'h0000;
			irq_served <= '0;
		end else begin
			irq_served <= '0;
			if (bus.intr_cmd_taken) begin
				cmd_pend <= 1'b0; // RULE21
			end else if (|bus.level_grant && !cmd_pend) begin
				cmd_pend <= 1'b1;
				bus.intr_vector <= cmd_vec; // RULE8
				for (int l = 0; l < 4; l++)
					if (bus.level_grant[l]) irq_served[l] <= irq_win[l];
			end
		end
	end
	assign bus.intr_cmd_valid = cmd_pend;
endmodule
`default_nettype wire

//--- testbench/bpie_asserts.sv
// Purpose: link checks between the processor and peripheral ends
// Assumes: one clock, reset active low
// Notes: sees only the interface signals
`timescale 1ns/10ps
`default_nettype none
module bpie_asserts (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// link
	input wire logic direct_transfer_request,
	input wire logic direct_transfer_grant,
	input wire logic [3:0] leveled_request_line,
	input wire logic [3:0] level_grant,
	input wire logic master_busy,
	input wire logic intr_cmd_valid,
	input wire logic [15:0] intr_vector,
	input wire logic intr_cmd_taken
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ==========================================
	// level grants
	chk_one_level: assert property ($onehot0(level_grant))
		else $error("several levels granted");
	chk_level_asked: assert property ($rose(|level_grant) |->
		|($past(leveled_request_line) & level_grant))
		else $error("grant without request");
	chk_highest_first: assert property ($rose(|level_grant) |->
		{1'b0, $past(leveled_request_line)} < {level_grant, 1'b0})
		else $error("lower level granted first");
	chk_grant_stands: assert property ((|level_grant && !intr_cmd_valid)
		|=> level_grant == $past(level_grant))
		else $error("grant dropped early");
	chk_taken_soon: assert property ($rose(|level_grant) |->
		##[1:8] intr_cmd_taken)
		else $error("command not taken");
	chk_taken_cause: assert property (intr_cmd_taken |->
		$past(intr_cmd_valid) && !$past(intr_cmd_taken))
		else $error("taken without command");
	chk_vector_held: assert property ((intr_cmd_valid &&
		!intr_cmd_taken) |=> $stable(intr_vector))
		else $error("vector moved while offered");
	chk_grant_release: assert property (intr_cmd_taken |->
		##[0:1] level_grant == 4'h0)
		else $error("grant kept after command");
	// ==========================================
	// direct transfers
	chk_direct_soon: assert property ((direct_transfer_request &&
		!direct_transfer_grant) |-> ##[1:875] direct_transfer_grant)
		else $error("direct grant late");
	chk_direct_free: assert property ((direct_transfer_grant &&
		!direct_transfer_request && !master_busy) |->
		##[0:1] !direct_transfer_grant)
		else $error("direct grant not released");
	chk_no_both: assert property (direct_transfer_grant |->
		level_grant == 4'h0)
		else $error("direct and level grant together");
endmodule
`default_nettype wire

//--- testbench/bpie_test.sv
// Purpose: drives both link ends and judges the results
// Assumes: 250 MHz mclk
// Notes: a vector at sp-4 reloads the context just pushed
`timescale 1ns/10ps
`default_nettype none
module bpie_test;
	logic mclk = 1'b0, resetn = 1'b0, rmw_active = 1'b0;
	logic return_request = 1'b0, prio_write_en = 1'b0;
	logic fetch_strobe, in_service, word_strobe;
	logic [2:0] prio_write = 3'h0;
	logic [1:0] dma_want = 2'h0, dma_owner;
	logic [3:0][1:0] irq_want = '0, irq_served;
	logic [3:0][1:0][15:0] irq_vector = '0;
	logic [15:0] ip, psw, sp, q_ip[$];
	int fail_count = 0, n_tests = 0, k, w;
	// ==========================================
	// clock and instances
	always #2 mclk = ~mclk;
	bpie_if u_bpie_if (.mclk(mclk), .resetn(resetn));
	bpie_cpu u_bpie_cpu (.bus(u_bpie_if.cpu), .mclk(mclk),
		.resetn(resetn),
		.rmw_active(rmw_active), .return_request(return_request),
		.prio_write(prio_write), .prio_write_en(prio_write_en),
		.instruction_pointer(ip), .processor_state_word(psw),
		.stack_top_register(sp), .fetch_strobe(fetch_strobe),
		.in_service(in_service));
	bpie_periph u_bpie_periph (.bus(u_bpie_if.periph), .mclk(mclk),
		.resetn(resetn), .dma_want(dma_want), .irq_want(irq_want),
		.irq_vector(irq_vector), .dma_owner(dma_owner),
		.irq_served(irq_served), .word_strobe(word_strobe));
	bpie_asserts u_chk (.mclk(mclk), .resetn(resetn),
		.direct_transfer_request(u_bpie_if.direct_transfer_request),
		.direct_transfer_grant(u_bpie_if.direct_transfer_grant),
		.leveled_request_line(u_bpie_if.leveled_request_line),
		.level_grant(u_bpie_if.level_grant),
		.master_busy(u_bpie_if.master_busy),
		.intr_cmd_valid(u_bpie_if.intr_cmd_valid),
		.intr_vector(u_bpie_if.intr_vector),
		.intr_cmd_taken(u_bpie_if.intr_cmd_taken));
	// ==========================================
	// helpers
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge mclk);
			#1;
		end
	endtask
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic limit(input int max);
		if (k >= max) begin
			fail_count++;
			give_verdict;
		end
	endtask
	task automatic quiet(input int n);
		logic [3:0] g;
		g = 4'h0;
		for (k = 0; k < n; k++) begin
			tick(1);
			g = g | u_bpie_if.level_grant;
		end
		cmp({12'h0, g}, 16'h0000);
	endtask
	task automatic set_prio(input logic [2:0] p);
		prio_write = p;
		prio_write_en = 1'b1;
		tick(1);
		prio_write_en = 1'b0;
		tick(2);
		cmp(psw & 16'h00E0, {8'h0, p, 5'h0});
	endtask
	// ==========================================
	// interrupt entry and return
	task automatic entry(input int lvl, input int slot,
		input logic [15:0] s, input logic [15:0] p);
		for (k = 0; k < 2000 && irq_served === '0; k++) tick(1);
		limit(2000);
		w = k;
		cmp({8'h0, irq_served}, 16'h0001 << (lvl * 2 + slot));
		irq_want[lvl][slot] = 1'b0;
		q_ip.push_back(ip);
		for (k = 0; k < 1800 && fetch_strobe !== 1'b1; k++) tick(1);
		limit(1800);
		tick(1);
		cmp(sp, s - 16'h0004);
		cmp(psw, p);
		cmp(ip, q_ip[$]);
		cmp({15'h0, in_service}, 16'h0001);
	endtask
	task automatic leave(input logic [15:0] s, input logic [15:0] p);
		return_request = 1'b1;
		tick(1);
		return_request = 1'b0;
		for (k = 0; k < 1125 && sp !== s; k++) tick(1);
		limit(1125);
		tick(2);
		cmp(psw, p);
		cmp(ip, q_ip.pop_back());
	endtask
	// ==========================================
	// scenarios
	task automatic t_dma;
		logic [47:0] ctx;
		rmw_active = 1'b1;
		dma_want = 2'h3;
		tick(40);
		cmp({14'h0, dma_owner}, 16'h0000);
		rmw_active = 1'b0;
		for (k = 0; k < 875 && dma_owner === 2'h0; k++) tick(1);
		limit(875);
		cmp({14'h0, dma_owner}, 16'h0001);
		ctx = {ip, psw, sp};
		for (k = 0; k < 400 && word_strobe !== 1'b1; k++) tick(1);
		limit(400);
		cmp(16'(k), 16'h012C);
		dma_want = 2'h2;
		for (k = 0; k < 875 && dma_owner !== 2'h2; k++) tick(1);
		limit(875);
		cmp(ip, ctx[47:32]);
		cmp(sp, ctx[15:0]);
		cmp(psw, ctx[31:16]);
		dma_want = 2'h0;
		tick(20);
		cmp({15'h0, u_bpie_if.direct_transfer_grant}, 16'h0000);
	endtask
	task automatic t_irq;
		irq_want[3][0] = 1'b1;
		quiet(60);
		irq_vector[3][0] = 16'h03FC;
		irq_vector[3][1] = 16'h03F8;
		irq_vector[2][0] = 16'h03FC;
		irq_vector[0][0] = 16'h03F8;
		irq_want[3][1] = 1'b1;
		irq_want[2][0] = 1'b1;
		set_prio(3'h6);
		entry(3, 0, 16'h0400, 16'h00C0);
		entry(3, 1, 16'h03FC, 16'h00C0);
		cmp({15'h0, w > 12}, 16'h0001);
		quiet(60);
		set_prio(3'h7);
		leave(16'h03FC, 16'h00C0);
		leave(16'h0400, 16'h00C0);
		cmp({15'h0, in_service}, 16'h0000);
		irq_want[0][0] = 1'b1;
		set_prio(3'h0);
		entry(2, 0, 16'h0400, 16'h0000);
		entry(0, 0, 16'h03FC, 16'h0000);
		set_prio(3'h5);
		leave(16'h03FC, 16'h0000);
		leave(16'h0400, 16'h0000);
	endtask
	// ==========================================
	// main sequence
	initial begin
		tick(5);
		resetn = 1'b1;
		tick(1);
		cmp(ip, 16'h0200);
		cmp(psw, 16'h00E0);
		cmp(sp, 16'h0400);
		t_dma;
		t_irq;
		give_verdict;
	end
endmodule
`default_nettype wire
